// ---- pkg/esm_pkg.sv ----
`default_nettype none
package esm_pkg;
	localparam int unsigned CLK_HZ        = 25_000_000;
	localparam int unsigned SEC_PER_MIN   = 60;
	localparam logic [31:0] RPM_NUM       = 32'(SEC_PER_MIN * CLK_HZ);
	localparam int unsigned SAMPLE_US     = 1000;
	localparam int unsigned SAMPLE_CYCLES = CLK_HZ / 1_000_000 * SAMPLE_US;
	localparam int unsigned FAILSAFE_PCT  = 5;
	localparam int unsigned PCT_FULL      = 100;
	// Notch frequency in tenths of a hertz, Q factor in thousandths
	localparam logic [15:0] NFREQ_MIN     = 16'h0005;
	localparam logic [15:0] NFREQ_MAX     = 16'h00A0;
	localparam logic [15:0] NQ_MIN        = 16'h02C3;
	localparam logic [15:0] NQ_MAX        = 16'h61A8;
	localparam logic [31:0] NGAIN_NUM     = 32'h02C3_0000;
	localparam logic [16:0] UNITY_Q16     = 17'h1_0000;
	localparam int          NF_STEP       = int'(6.2831853 * 0.1 * SAMPLE_US * 1.0e-6 * 65536.0);
	localparam logic [23:0] PERIOD_MAX    = 24'hFF_FFFF;
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_TEETH    = 8'h04;
	localparam logic [7:0]  ADDR_RATED    = 8'h08;
	localparam logic [7:0]  ADDR_OVSPD    = 8'h0C;
	localparam logic [7:0]  ADDR_LPF      = 8'h10;
	localparam logic [7:0]  ADDR_NFREQ    = 8'h14;
	localparam logic [7:0]  ADDR_NQ       = 8'h18;
	localparam logic [7:0]  ADDR_TORS     = 8'h1C;
	localparam logic [7:0]  ADDR_SPEED    = 8'h20;
	localparam logic [7:0]  ADDR_STATUS   = 8'h24;
	localparam logic [7:0]  ADDR_IRQ_STAT = 8'h28;
	localparam logic [7:0]  ADDR_IRQ_MASK = 8'h2C;
	localparam logic [7:0]  ADDR_CH_SPEED = 8'h30;
	localparam int          CTRL_USE1     = 0;
	localparam int          CTRL_USE2     = 1;
	localparam int          CTRL_TORS     = 2;
	localparam int          CTRL_NOTCH    = 3;
	localparam int          CTRL_CLRALL   = 4;
	localparam int          CTRL_RESTART  = 5;
	localparam int          IRQ_W         = 4;
	localparam logic [15:0] RST_TEETH     = 16'h3C3C;
	localparam logic [15:0] RST_RATED     = 16'h0708;
	localparam logic [15:0] RST_OVSPD     = 16'h0816;
	localparam logic [15:0] RST_LPF       = 16'h1000;
	localparam logic [15:0] RST_NFREQ     = 16'h000A;
	localparam logic [15:0] RST_TORS      = 16'h8000;
	localparam logic [3:0]  RST_CTRL      = 4'h1;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LOAD = 4'b0010,
		ST_DIV  = 4'b0100,
		ST_FILT = 4'b1000
	} esm_state_type;
	typedef struct packed {
		logic [1:0]  use_in;
		logic        coupling_mode_select;
		logic        notch_en;
		logic [7:0]  teeth2;
		logic [7:0]  teeth1;
		logic [15:0] rated;
		logic [15:0] overspeed_limit;
		logic [15:0] lowpass_cutoff_setting;
		logic [15:0] notch_freq;
		logic [15:0] notch_q;
		logic [15:0] tors_ratio;
	} esm_cfg_type;
endpackage
`default_nettype wire

// ---- hdl/esm_speed_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module esm_speed_monitor #(
	parameter int unsigned SAMPLE_CYC = esm_pkg::SAMPLE_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        irq,
	input  wire logic [1:0]  pickup_sensor,
	input  wire logic [1:0]  pickup_amp_ok,
	output var  logic [1:0]  sensor_fault_lamp,
	output var  logic        fuel_min,
	output var  logic        actuator_shutdown,
	output var  logic        overspeed_fault
);
	import esm_pkg::*;

	function automatic logic [31:0] lp_step(input logic [31:0] s, input logic [31:0] x,
		input logic [15:0] a);
		logic signed [33:0] d;
		logic signed [50:0] p;
		d = $signed({2'b00, x}) - $signed({2'b00, s});
		p = d * $signed({1'b0, a});
		lp_step = s + 32'(p >>> 16);
	endfunction

	function automatic logic signed [33:0] mq16(input logic signed [33:0] a,
		input logic signed [17:0] b);
		logic signed [51:0] p;
		p = a * b;
		mq16 = 34'(p >>> 16);
	endfunction

	logic [1:0]  pk_m_r, pk_s_r, pk_d_r, amp_m_r, amp_s_r, pk_edge;
	esm_cfg_type cfg_r, cfg_nxt;
	logic [IRQ_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt, ev;
	logic [31:0] prdata_nxt;
	logic        pready_nxt, pslverr_nxt, irq_nxt, clr_r, clr_nxt, rst_r, rst_nxt;
	logic [1:0][23:0] period;
	logic [1:0][15:0] lp_spd, rpm_r, rpm_nxt;
	esm_state_type st_r, st_nxt;
	logic [1:0]  job_r, job_nxt;
	logic [4:0]  bit_r, bit_nxt;
	logic [32:0] rem_r, rem_nxt, rem_sh;
	logic [31:0] quo_r, quo_nxt, den_r, den_nxt, q_fin, res;
	logic [23:0] tick_r, tick_nxt;
	logic [16:0] gain_r, gain_nxt;
	logic [15:0] fs_r, fs_nxt, spd_r, spd_nxt, sel;
	logic signed [33:0] nbp_r, nbp_nxt, nlp_r, nlp_nxt, x34, hp, y;
	logic signed [17:0] fco;
	logic [32:0] blend;
	logic [1:0]  fault_r, fault_nxt;
	logic        run, run_q_r, ovs_set, ovs_nxt, ovs_r, shut_nxt, shut_r, fmin_nxt, fmin_r;

	// Pickup pulses and amplitude comparators are asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn) begin
			pk_m_r  <= '0;
			pk_s_r  <= '0;
			pk_d_r  <= '0;
			amp_m_r <= '0;
			amp_s_r <= '0;
		end else begin
			pk_m_r  <= pickup_sensor;
			pk_s_r  <= pk_m_r;
			pk_d_r  <= pk_s_r;
			amp_m_r <= pickup_amp_ok;
			amp_s_r <= amp_m_r;
		end
	end
	assign pk_edge = pk_s_r & ~pk_d_r;

	// APB slave: one wait state, writes land at the edge that samples pready high
	always_comb
	begin
		logic acc, done;
		acc         = psel & penable;
		done        = acc & pready;
		cfg_nxt     = cfg_r;
		imask_nxt   = imask_r;
		clr_nxt     = 1'b0;
		rst_nxt     = 1'b0;
		pready_nxt  = acc & ~pready;
		pslverr_nxt = 1'b0;
		prdata_nxt  = prdata;
		ist_nxt     = ist_r;
		// Only bits actually returned are cleared, so a late event is never lost
		if (done && !pwrite && paddr == ADDR_IRQ_STAT)
			ist_nxt = ist_r & ~prdata[IRQ_W-1:0];
		ist_nxt = ist_nxt | ev;
		if (acc && !pready) begin
			prdata_nxt = '0;
			case (paddr)
			ADDR_CTRL:     prdata_nxt[3:0] = {cfg_r.notch_en, cfg_r.coupling_mode_select,
				cfg_r.use_in};
			ADDR_TEETH:    prdata_nxt[15:0] = {cfg_r.teeth2, cfg_r.teeth1};
			ADDR_RATED:    prdata_nxt[15:0] = cfg_r.rated;
			ADDR_OVSPD:    prdata_nxt[15:0] = cfg_r.overspeed_limit;
			ADDR_LPF:      prdata_nxt[15:0] = cfg_r.lowpass_cutoff_setting;
			ADDR_NFREQ:    prdata_nxt[15:0] = cfg_r.notch_freq;
			ADDR_NQ:       prdata_nxt[15:0] = cfg_r.notch_q;
			ADDR_TORS:     prdata_nxt[15:0] = cfg_r.tors_ratio;
			ADDR_SPEED:    prdata_nxt = {fs_r, spd_r};
			ADDR_STATUS:   prdata_nxt[5:0] = {run_q_r, fmin_r, shut_r, ovs_r, fault_r};
			ADDR_IRQ_STAT: prdata_nxt[IRQ_W-1:0] = ist_r;
			ADDR_IRQ_MASK: prdata_nxt[IRQ_W-1:0] = imask_r;
			ADDR_CH_SPEED: prdata_nxt = {lp_spd[1], lp_spd[0]};
			default:       pslverr_nxt = 1'b1;
			endcase
		end
		if (done && pwrite) begin
			case (paddr)
			ADDR_CTRL:
			begin
				cfg_nxt.use_in               = pwdata[CTRL_USE2:CTRL_USE1];
				cfg_nxt.coupling_mode_select = pwdata[CTRL_TORS];
				cfg_nxt.notch_en             = pwdata[CTRL_NOTCH];
				clr_nxt                      = pwdata[CTRL_CLRALL];
				rst_nxt                      = pwdata[CTRL_RESTART];
			end
			ADDR_TEETH:    {cfg_nxt.teeth2, cfg_nxt.teeth1} = pwdata[15:0];
			ADDR_RATED:    cfg_nxt.rated = pwdata[15:0];
			ADDR_OVSPD:    cfg_nxt.overspeed_limit = pwdata[15:0];
			ADDR_LPF:      cfg_nxt.lowpass_cutoff_setting = pwdata[15:0];
			ADDR_NFREQ:    cfg_nxt.notch_freq = (pwdata[15:0] < NFREQ_MIN) ? NFREQ_MIN :
				(pwdata[15:0] > NFREQ_MAX) ? NFREQ_MAX : pwdata[15:0];
			ADDR_NQ:       cfg_nxt.notch_q = (pwdata[15:0] < NQ_MIN) ? NQ_MIN :
				(pwdata[15:0] > NQ_MAX) ? NQ_MAX : pwdata[15:0];
			ADDR_TORS:     cfg_nxt.tors_ratio = pwdata[15:0];
			ADDR_IRQ_MASK: imask_nxt = pwdata[IRQ_W-1:0];
			default:       imask_nxt = imask_r;
			endcase
		end
		irq_nxt = |(ist_nxt & imask_nxt);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn) begin
			cfg_r   <= '{use_in: RST_CTRL[1:0], coupling_mode_select: 1'b0, notch_en: 1'b0,
				teeth2: RST_TEETH[15:8], teeth1: RST_TEETH[7:0], rated: RST_RATED,
				overspeed_limit: RST_OVSPD, lowpass_cutoff_setting: RST_LPF,
				notch_freq: RST_NFREQ, notch_q: NQ_MIN, tors_ratio: RST_TORS};
			imask_r <= '0;
			ist_r   <= '0;
			clr_r   <= 1'b0;
			rst_r   <= 1'b0;
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			irq     <= 1'b0;
		end else begin
			cfg_r   <= cfg_nxt;
			imask_r <= imask_nxt;
			ist_r   <= ist_nxt;
			clr_r   <= clr_nxt;
			rst_r   <= rst_nxt;
			prdata  <= prdata_nxt;
			pready  <= pready_nxt;
			pslverr <= pslverr_nxt;
			irq     <= irq_nxt;
		end
	end

	// Per input: tooth period measurement and the two-pole low-pass section
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_ch
			logic [23:0] cnt_r, cnt_nxt, per_r, per_nxt;
			logic [31:0] s1_r, s1_nxt, s2_r, s2_nxt;
			always_comb
			begin
				cnt_nxt = cnt_r;
				per_nxt = per_r;
				s1_nxt  = s1_r;
				s2_nxt  = s2_r;
				if (pk_edge[g]) begin
					per_nxt = cnt_r;
					cnt_nxt = 24'h00_0001;
				end else if (cnt_r == PERIOD_MAX)
					per_nxt = '0;
				else
					cnt_nxt = cnt_r + 24'h00_0001;
				if (st_r == ST_FILT) begin
					s1_nxt = lp_step(s1_r, {rpm_r[g], 16'h0000},
						cfg_r.lowpass_cutoff_setting);
					s2_nxt = lp_step(s2_r, s1_nxt, cfg_r.lowpass_cutoff_setting);
				end
			end
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn) begin
					cnt_r <= PERIOD_MAX;
					per_r <= '0;
					s1_r  <= '0;
					s2_r  <= '0;
				end else begin
					cnt_r <= cnt_nxt;
					per_r <= per_nxt;
					s1_r  <= s1_nxt;
					s2_r  <= s2_nxt;
				end
			end
			assign period[g] = per_r;
			assign lp_spd[g] = s2_r[31:16];
		end
	endgenerate

	// Sample sequencer: four shared divisions, then one filter update
	always_comb
	begin
		st_nxt   = st_r;
		job_nxt  = job_r;
		bit_nxt  = bit_r;
		rem_nxt  = rem_r;
		quo_nxt  = quo_r;
		den_nxt  = den_r;
		rpm_nxt  = rpm_r;
		gain_nxt = gain_r;
		fs_nxt   = fs_r;
		nbp_nxt  = nbp_r;
		nlp_nxt  = nlp_r;
		spd_nxt  = spd_r;
		y        = '0;
		tick_nxt = (tick_r == '0) ? 24'(SAMPLE_CYC - 1) : tick_r - 24'h00_0001;
		rem_sh   = {rem_r[31:0], quo_r[31]};
		q_fin    = {quo_r[30:0], (rem_sh >= {1'b0, den_r})};
		res      = (den_r == '0) ? '0 : q_fin;
		case (st_r)
		ST_IDLE:
			if (tick_r == '0) begin
				st_nxt  = ST_LOAD;
				job_nxt = 2'h0;
			end
		ST_LOAD:
		begin
			rem_nxt = '0;
			bit_nxt = '0;
			st_nxt  = ST_DIV;
			case (job_r)
			2'h0: begin quo_nxt = RPM_NUM; den_nxt = 32'(cfg_r.teeth1) * 32'(period[0]); end
			2'h1: begin quo_nxt = RPM_NUM; den_nxt = 32'(cfg_r.teeth2) * 32'(period[1]); end
			2'h2: begin quo_nxt = NGAIN_NUM; den_nxt = 32'(cfg_r.notch_q); end
			default: begin quo_nxt = 32'(cfg_r.rated) * FAILSAFE_PCT; den_nxt = PCT_FULL; end
			endcase
		end
		ST_DIV:
		begin
			rem_nxt = (rem_sh >= {1'b0, den_r}) ? rem_sh - {1'b0, den_r} : rem_sh;
			quo_nxt = q_fin;
			bit_nxt = bit_r + 5'h01;
			if (bit_r == 5'h1F) begin
				case (job_r)
				2'h0: rpm_nxt[0] = (res > 32'h0000_FFFF) ? 16'hFFFF : res[15:0];
				2'h1: rpm_nxt[1] = (res > 32'h0000_FFFF) ? 16'hFFFF : res[15:0];
				2'h2: gain_nxt = res[16:0];
				default: fs_nxt = res[15:0];
				endcase
				st_nxt  = (job_r == 2'h3) ? ST_FILT : ST_LOAD;
				job_nxt = job_r + 2'h1;
			end
		end
		ST_FILT:
		begin
			st_nxt = ST_IDLE;
			if (&cfg_r.use_in) begin
				// Blend only while both pickups are healthy
				if (cfg_r.coupling_mode_select && fault_r == 2'b00)
					spd_nxt = blend[31:16];
				else
					spd_nxt = (lp_spd[0] > lp_spd[1]) ? lp_spd[0] : lp_spd[1];
			end else
				spd_nxt = cfg_r.use_in[1] ? lp_spd[1] : (cfg_r.use_in[0] ? lp_spd[0] : '0);
			nbp_nxt = nbp_r + mq16(hp, fco);
			nlp_nxt = nlp_r + mq16(nbp_nxt, fco);
			if (cfg_r.notch_en) begin
				y = x34 - mq16(nbp_nxt, $signed({1'b0, UNITY_Q16 - gain_r}));
				spd_nxt = y[33] ? 16'h0000 : (y[32] ? 16'hFFFF : y[31:16]);
			end
		end
		default: st_nxt = ST_IDLE;
		endcase
	end

	assign blend = 33'(cfg_r.tors_ratio) * 33'(lp_spd[0])
		+ (33'(UNITY_Q16) - 33'(cfg_r.tors_ratio)) * 33'(lp_spd[1]);
	assign sel   = (&cfg_r.use_in && cfg_r.coupling_mode_select && fault_r == 2'b00) ?
		blend[31:16] : ((lp_spd[0] > lp_spd[1]) ? lp_spd[0] : lp_spd[1]);
	assign x34   = $signed({2'b00, sel, 16'h0000});
	assign hp    = x34 - nlp_r - nbp_r;
	assign fco   = 18'(NF_STEP * int'(cfg_r.notch_freq));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn) begin
			st_r   <= ST_IDLE;
			job_r  <= '0;
			bit_r  <= '0;
			rem_r  <= '0;
			quo_r  <= '0;
			den_r  <= '0;
			tick_r <= '0;
			rpm_r  <= '0;
			gain_r <= UNITY_Q16;
			fs_r   <= 16'hFFFF;
			nbp_r  <= '0;
			nlp_r  <= '0;
			spd_r  <= '0;
		end else begin
			st_r   <= st_nxt;
			job_r  <= job_nxt;
			bit_r  <= bit_nxt;
			rem_r  <= rem_nxt;
			quo_r  <= quo_nxt;
			den_r  <= den_nxt;
			tick_r <= tick_nxt;
			rpm_r  <= rpm_nxt;
			gain_r <= gain_nxt;
			fs_r   <= fs_nxt;
			nbp_r  <= nbp_nxt;
			nlp_r  <= nlp_nxt;
			spd_r  <= spd_nxt;
		end
	end

	// Fault supervision; failsafe resets high so nothing runs before it is computed
	always_comb
	begin
		run     = spd_r >= fs_r;
		ovs_set = spd_r > cfg_r.overspeed_limit;
		for (int i = 0; i < 2; i++)
			fault_nxt[i] = cfg_r.use_in[i] ? (~amp_s_r[i] | (lp_spd[i] < fs_r)) : run;
		shut_nxt = ~run;
		// Set wins over every clear source
		ovs_nxt  = ovs_set | (ovs_r & ~((run & ~run_q_r) | clr_r | rst_r));
		fmin_nxt = ovs_nxt | shut_nxt | |(cfg_r.use_in & ~amp_s_r);
		ev       = {shut_nxt & ~shut_r, fault_nxt & ~fault_r, ovs_nxt & ~ovs_r};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn) begin
			fault_r <= '0;
			ovs_r   <= 1'b0;
			shut_r  <= 1'b1;
			fmin_r  <= 1'b1;
			run_q_r <= 1'b0;
		end else begin
			fault_r <= fault_nxt;
			ovs_r   <= ovs_nxt;
			shut_r  <= shut_nxt;
			fmin_r  <= fmin_nxt;
			run_q_r <= run;
		end
	end

	assign sensor_fault_lamp = fault_r;
	assign overspeed_fault   = ovs_r;
	assign actuator_shutdown = shut_r;
	assign fuel_min          = fmin_r;
endmodule // esm_speed_monitor
`default_nettype wire

// ---- test/esm_speed_monitor_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module esm_speed_monitor_props
	import esm_pkg::*;
#(
	parameter int unsigned SAMPLE_CYC = 400
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq,
	input wire logic        fuel_min,
	input wire logic        actuator_shutdown,
	input wire logic        overspeed_fault
);
	logic       wr_done;
	logic       clr_cause;
	logic       shut_r;
	logic [3:0] since_r;
	logic [3:0] since_nxt;
	assign wr_done = psel && penable && pready && pwrite;
	// A clear-all or restart write, or the speed climbing back over failsafe
	assign clr_cause = (wr_done && paddr == ADDR_CTRL && |pwdata[5:4])
		|| (shut_r && !actuator_shutdown);
	always_comb
	begin
		since_nxt = (since_r == 4'hF) ? since_r : since_r + 4'h1;
		if (clr_cause)
			since_nxt = 4'h0;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			since_r <= 4'hF;
			shut_r  <= 1'b1;
		end
		else
		begin
			since_r <= since_nxt;
			shut_r  <= actuator_shutdown;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && $rose(penable);
	endsequence
	sequence s_one_wait;
		!pready ##1 pready;
	endsequence
	a_one_wait_state: assert property (s_access |-> s_one_wait)
		else $error("pready not one cycle after access start");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("pslverr without pready or with data");
	a_decode_err: assert property (pready |-> pslverr == (paddr > ADDR_CH_SPEED))
		else $error("pslverr does not match address decode");
	a_mask_off: assert property ((wr_done && paddr == ADDR_IRQ_MASK
		&& pwdata[IRQ_W-1:0] == 4'h0) |-> ##2 !irq)
		else $error("irq high with every source masked");
	a_ovs_min_fuel: assert property (overspeed_fault |-> fuel_min)
		else $error("overspeed without minimum fuel");
	a_shut_min_fuel: assert property (actuator_shutdown |-> fuel_min)
		else $error("shutdown without minimum fuel");
	a_ovs_latch_hold: assert property ($fell(overspeed_fault) |-> clr_cause || since_r <= 4'h8)
		else $error("overspeed latch dropped with no clear cause");
endmodule // esm_speed_monitor_props
bind esm_speed_monitor esm_speed_monitor_props #(.SAMPLE_CYC(SAMPLE_CYC)) u_props (
	.pclk(pclk),
	.presetn(presetn),
	.paddr(paddr),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.irq(irq),
	.fuel_min(fuel_min),
	.actuator_shutdown(actuator_shutdown),
	.overspeed_fault(overspeed_fault)
);
`default_nettype wire

// ---- test/esm_pickup_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module esm_pickup_model (
	input  wire logic        pclk,
	input  wire logic [31:0] periods,
	input  wire logic [1:0]  amp_in,
	output var  logic [1:0]  pickup_sensor,
	output var  logic [1:0]  pickup_amp_ok
);
	logic [15:0] cnt [2];
	logic [15:0] p;
	// Amplitude passes through; the bench lowers it to fake a weak coil
	assign pickup_amp_ok = amp_in;
	initial
	begin
		cnt = '{16'h0000, 16'h0000};
		pickup_sensor = 2'b00;
	end
	// Period zero stands the wheel still with the coil output low
	always @(posedge pclk)
	begin
		for (int i = 0; i < 2; i++)
		begin
			p = periods[16*i +: 16];
			cnt[i] <= (p == 16'h0000 || cnt[i] + 16'h0001 >= p) ? 16'h0000 : cnt[i] + 16'h0001;
			pickup_sensor[i] <= (p != 16'h0000) && (cnt[i] < (p >> 1));
		end
	end
endmodule // esm_pickup_model
`default_nettype wire

// ---- test/esm_speed_monitor_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module esm_speed_monitor_tb_top;
	import esm_pkg::*;
	localparam int unsigned SC = 400;
	logic        pclk;
	logic        presetn;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [1:0]  pickup_sensor;
	logic [1:0]  pickup_amp_ok;
	logic [1:0]  sensor_fault_lamp;
	logic        fuel_min;
	logic        actuator_shutdown;
	logic        overspeed_fault;
	logic [31:0] periods;
	logic [1:0]  amp_in;
	logic [31:0] rd;
	logic        er;
	logic [31:0] seed;
	logic [31:0] e1;
	logic [31:0] e2;
	logic [15:0] w;
	int          n_fail;
	int          comparisons;
	logic [7:0]  ra [8] = '{ADDR_CTRL, ADDR_TEETH, ADDR_RATED, ADDR_OVSPD,
		ADDR_LPF, ADDR_NFREQ, ADDR_NQ, ADDR_TORS};
	logic [15:0] rv [8] = '{16'(RST_CTRL), RST_TEETH, RST_RATED, RST_OVSPD,
		RST_LPF, RST_NFREQ, NQ_MIN, RST_TORS};

	esm_speed_monitor #(.SAMPLE_CYC(SC)) dut (
		.pclk(pclk),
		.presetn(presetn),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.irq(irq),
		.pickup_sensor(pickup_sensor),
		.pickup_amp_ok(pickup_amp_ok),
		.sensor_fault_lamp(sensor_fault_lamp),
		.fuel_min(fuel_min),
		.actuator_shutdown(actuator_shutdown),
		.overspeed_fault(overspeed_fault)
	);
	esm_pickup_model u_pick (
		.pclk(pclk),
		.periods(periods),
		.amp_in(amp_in),
		.pickup_sensor(pickup_sensor),
		.pickup_amp_ok(pickup_amp_ok)
	);

	initial
	begin
		pclk = 1'b0;
		forever
			#20 pclk = ~pclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	// Both wheels are programmed with 255 teeth
	function automatic logic [31:0] rpm(input logic [15:0] p);
		return RPM_NUM / (32'h0000_00FF * p);
	endfunction
	// Filters leave a small ripple, so speeds are judged within 2 percent plus 3 rpm
	function automatic logic near(input logic [31:0] s, input logic [31:0] e);
		logic [31:0] t;
		t = e / 32'h0000_0032 + 32'h0000_0003;
		return (s + t >= e) && (s <= e + t);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// pready is read at the rising edge, before that edge's updates land
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k >= 50)
			n_fail++;
	endtask
	task automatic rdck(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		check(rd, e);
	endtask
	task automatic settle(input int n);
		repeat (n * SC) @(posedge pclk);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		repeat (90000) @(posedge pclk);
		n_fail++;
		tally_and_finish();
	end

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		periods = 32'h0000_0000;
		amp_in = 2'b11;
		n_fail = 0;
		comparisons = 0;
		seed = 32'h0000_99CC;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ra[i])
			rdck(ra[i], 32'(rv[i]));
		rdck(8'h40, 32'h0000_0000);
		check(32'(er), 32'h0000_0001);
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, i[1] ? ADDR_NQ : ADDR_NFREQ, i[0] ? 32'h0000_FFFF : 32'h0000_0000);
			rdck(i[1] ? ADDR_NQ : ADDR_NFREQ, i[1] ? (i[0] ? NQ_MAX : NQ_MIN) : (i[0] ? NFREQ_MAX : NFREQ_MIN));
		end
		apb(1'b1, ADDR_TEETH, 32'h0000_FFFF);
		apb(1'b1, ADDR_LPF, 32'h0000_FFFF);
		apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
		apb(1'b1, ADDR_CTRL, 32'h0000_0013);
		rdck(ADDR_CTRL, 32'h0000_0003);
		for (int i = 0; i < 2; i++)
		begin
			seed = xs(seed);
			periods[15:0] <= 16'h0C80 + 16'(seed[10:0]);
			e1 = rpm(16'h0C80 + 16'(seed[10:0]));
			seed = xs(seed);
			periods[31:16] <= 16'h0C80 + 16'(seed[10:0]);
			e2 = rpm(16'h0C80 + 16'(seed[10:0]));
			settle(35);
			apb(1'b0, ADDR_CH_SPEED, 32'h0000_0000);
			check(32'(near(32'(rd[15:0]), e1)), 32'h0000_0001);
			check(32'(near(32'(rd[31:16]), e2)), 32'h0000_0001);
			apb(1'b0, ADDR_SPEED, 32'h0000_0000);
			check(32'(near(32'(rd[15:0]), (e1 > e2) ? e1 : e2)), 32'h0000_0001);
			check(32'(rd[31:16]), 32'(RST_RATED) * FAILSAFE_PCT / PCT_FULL);
			rdck(ADDR_STATUS, 32'h0000_0020);
		end
		periods <= 32'h0FA0_0DAC;
		e1 = rpm(16'h0DAC);
		e2 = rpm(16'h0FA0);
		seed = xs(seed);
		w = seed[15:0];
		apb(1'b1, ADDR_TORS, 32'(w));
		apb(1'b1, ADDR_CTRL, 32'h0000_0007);
		settle(20);
		apb(1'b0, ADDR_SPEED, 32'h0000_0000);
		check(32'(near(32'(rd[15:0]), (32'(w) * e1 + (32'h0001_0000 - w) * e2) >> 16)), 32'h0000_0001);
		amp_in <= 2'b01;
		settle(5);
		check(32'(sensor_fault_lamp), 32'h0000_0002);
		apb(1'b0, ADDR_SPEED, 32'h0000_0000);
		check(32'(near(32'(rd[15:0]), e1)), 32'h0000_0001);
		amp_in <= 2'b11;
		for (int u = 1; u < 3; u++)
		begin
			apb(1'b1, ADDR_CTRL, 32'(u));
			settle(5);
			check(32'(sensor_fault_lamp), 32'(3 - u));
		end
		apb(1'b1, ADDR_CTRL, 32'h0000_0003);
		// Earlier lamp events are still pending; drain them before the overspeed test
		apb(1'b0, ADDR_IRQ_STAT, 32'h0000_0000);
		for (int k = 0; k < 3; k++)
		begin
			apb(1'b1, ADDR_OVSPD, 32'h0000_0640);
			settle(3);
			check(32'({overspeed_fault, fuel_min}), 32'h0000_0003);
			if (k == 0)
			begin
				check(32'(irq), 32'h0000_0001);
				rdck(ADDR_IRQ_STAT, 32'h0000_0001);
				apb(1'b0, ADDR_IRQ_STAT, 32'h0000_0000);
				check(32'(rd[0]), 32'h0000_0000);
			end
			apb(1'b1, ADDR_OVSPD, 32'(RST_OVSPD));
			settle(2);
			check(32'(overspeed_fault), 32'h0000_0001);
			if (k < 2)
				apb(1'b1, ADDR_CTRL, k ? 32'h0000_0023 : 32'h0000_0013);
			else
			begin
				apb(1'b1, ADDR_RATED, 32'h0000_FFFF);
				settle(3);
				check(32'({actuator_shutdown, sensor_fault_lamp}), 32'h0000_0007);
				apb(1'b0, ADDR_SPEED, 32'h0000_0000);
				check(32'(rd[31:16]), 32'h0000_FFFF * FAILSAFE_PCT / PCT_FULL);
				apb(1'b1, ADDR_RATED, 32'(RST_RATED));
			end
			settle(3);
			check(32'({overspeed_fault, actuator_shutdown}), 32'h0000_0000);
		end
		apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0000);
		settle(1);
		tally_and_finish();
	end
endmodule // esm_speed_monitor_tb_top
`default_nettype wire
